// >>> shared/sram_host_pkg.sv
// package for the 4k x 4 static memory host controller
// assumes a 50 MHz system clock; timing figures are the slowest speed grade
package sram_host_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int MEM_WORDS = 4096;

  // clock period in picoseconds
  localparam int CLK_PS = 20000;

  // grade timing in nanoseconds (slowest grade covers all three)
  localparam int READ_CYCLE_MIN_NS = 35;
  localparam int ADDRESS_TO_DATA_DELAY_NS = 35;
  localparam int SELECT_TO_DATA_DELAY_NS = 35;
  localparam int DESELECT_TO_FLOAT_DELAY_NS = 13;
  localparam int WRITE_TO_FLOAT_DELAY_NS = 13;
  localparam int WRITE_RELEASE_TO_DRIVE_NS = 5;
  localparam int DATA_SETUP_BEFORE_WRITE_NS = 15;
  localparam int SELECT_TO_WRITE_END_MIN_NS = 32;
  localparam int ADDRESS_TO_WRITE_END_MIN_NS = 30;
  localparam int WRITE_CYCLE_MIN_NS = 35;
  localparam int POWER_DOWN_DELAY_NS = 35;

  // least times round up to whole cycles, at least one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 4;
  // read: wait access time, then sample
  localparam logic [CNT_W-1:0] READ_WAIT_CYC =
    CNT_W'(ceil_cyc(ADDRESS_TO_DATA_DELAY_NS > SELECT_TO_DATA_DELAY_NS ?
      ADDRESS_TO_DATA_DELAY_NS : SELECT_TO_DATA_DELAY_NS) + 1);
  // write low pulse covers select, address and data setup to end of write
  localparam logic [CNT_W-1:0] WRITE_PULSE_CYC =
    CNT_W'(ceil_cyc(SELECT_TO_WRITE_END_MIN_NS));
  // bus turnaround after deselect or write strobe
  localparam logic [CNT_W-1:0] FLOAT_WAIT_CYC =
    CNT_W'(ceil_cyc(DESELECT_TO_FLOAT_DELAY_NS > WRITE_TO_FLOAT_DELAY_NS ?
      DESELECT_TO_FLOAT_DELAY_NS : WRITE_TO_FLOAT_DELAY_NS));
  // recovery counted from entry to ST_RECOVER; first access waits for it and for supply
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(ceil_cyc(READ_CYCLE_MIN_NS));

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic select_n;
    logic write_strobe_n;
    logic [ADDR_W-1:0] addr;
  } mem_pins_t;

  typedef enum logic [2:0] {
    ST_RECOVER = 3'b000,
    ST_IDLE    = 3'b001,
    ST_READ    = 3'b010,
    ST_WSETUP  = 3'b011,
    ST_WPULSE  = 3'b100,
    ST_WEND    = 3'b101,
    ST_FLOAT   = 3'b110
  } host_state_t;

endpackage

// >>> core/pin_sync.sv
// two flip-flop synchroniser for a bus of pin inputs
// assumes the pins are asynchronous to mclk_i
`timescale 1ns/1ps
module pin_sync
  import sram_host_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_r <= '0;
      sync_o <= '0;
    end else begin
      stage1_r <= async_i;
      sync_o <= stage1_r;
    end
  end

endmodule

// >>> core/sram_host.sv
// host controller driving a 4k x 4 asynchronous static memory over its pins
// assumes one request at a time from user logic, slowest speed grade timing
//
// What this block does
// RULE1: memory is static; host needs no refresh
// RULE2: read with strobe high, select low
// RULE3: twelve address lines pick one nibble
// RULE4: sample read data after address access time
// RULE5: memory may drive early; host waits
// RULE6: next access no sooner than cycle time
// RULE7: select access time bounds sample point
// RULE8: old data held briefly after address change
// RULE9: deselect floats memory data within limit
// RULE10: strobe stays high throughout reads
// RULE11: write while strobe and select low
// RULE12: address changes only with strobe high
// RULE13: address held through end of write
// RULE14: strobe fall floats memory outputs
// RULE15: write data set up before write end
// RULE16: select and strobe low long enough
// RULE17: write cycle no shorter than minimum
// RULE18: memory redrives only after strobe rise
// RULE19: deselect gives standby on enable variant
// RULE20: power-down after deselect; instant power-up
// RULE21: deselect during retention, wait recovery
// RULE22: counters pace access; release bus first
`timescale 1ns/1ps
module sram_host
  import sram_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // user side
  input wire logic req_valid_i,
  input wire mem_req_t req_i,
  output logic req_ready_o,
  output logic rdata_valid_o,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic supply_ok_i,
  output logic busy_o,
  // memory pins
  output logic [ADDR_W-1:0] addr_inputs_o,
  output logic select_n_o,
  output logic write_strobe_n_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [DATA_W-1:0] data_sync;
  logic supply_ok_sync;

  pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({supply_ok_i, data_i}),
    .sync_o({supply_ok_sync, data_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  host_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic cnt_done;
  mem_pins_t pins_r;
  logic write_r;
  logic [DATA_W-1:0] wdata_r;
  logic sample_wait_r;

  assign cnt_done = (cnt_r == '0);
  assign req_ready_o = (state_r == ST_IDLE) && supply_ok_sync;
  assign busy_o = (state_r != ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RECOVER: if (cnt_done && supply_ok_sync) state_nxt = ST_IDLE; // RULE21
      ST_IDLE: begin
        if (!supply_ok_sync) state_nxt = ST_RECOVER; // RULE21
        else if (req_valid_i && req_i.write) state_nxt = ST_WSETUP;
        else if (req_valid_i) state_nxt = ST_READ; // RULE2
      end
      ST_READ: if (cnt_done) state_nxt = ST_FLOAT; // RULE4 RULE7
      ST_WSETUP: state_nxt = ST_WPULSE; // RULE12
      ST_WPULSE: if (cnt_done) state_nxt = ST_WEND; // RULE16
      ST_WEND: state_nxt = ST_FLOAT; // RULE13
      ST_FLOAT: if (cnt_done) state_nxt = ST_IDLE; // RULE9 RULE22
      default: state_nxt = ST_RECOVER;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RECOVER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle counter loaded on each state entry
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= RECOVER_CYC;
    end else if (state_nxt != state_r) begin
      unique case (state_nxt)
        ST_RECOVER: cnt_r <= RECOVER_CYC; // RULE21
        ST_READ: cnt_r <= READ_WAIT_CYC; // RULE4 RULE6
        ST_WPULSE: cnt_r <= WRITE_PULSE_CYC; // RULE15 RULE16 RULE17
        ST_FLOAT: cnt_r <= FLOAT_WAIT_CYC; // RULE14 RULE18
        default: cnt_r <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory pins, all from flip-flops

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_r <= '{select_n: 1'b1, write_strobe_n: 1'b1, addr: '0};
      write_r <= 1'b0;
      wdata_r <= '0;
    end else begin
      unique case (state_nxt)
        ST_READ: begin
          // address taken at entry only, stable for whole access
          if (state_r == ST_IDLE) pins_r.addr <= req_i.addr; // RULE3
          pins_r.select_n <= 1'b0; // RULE2
          pins_r.write_strobe_n <= 1'b1; // RULE10
        end
        ST_WSETUP: begin
          // address settles while deselected, so memory never drives here
          pins_r.addr <= req_i.addr; // RULE12
          pins_r.select_n <= 1'b1;
          pins_r.write_strobe_n <= 1'b1;
          wdata_r <= req_i.wdata;
        end
        ST_WPULSE: begin
          // select and strobe fall together: memory stays in write mode
          pins_r.select_n <= 1'b0; // RULE11
          pins_r.write_strobe_n <= 1'b0; // RULE11
          write_r <= 1'b1; // RULE15
        end
        ST_WEND: begin
          // both rise together so memory cannot redrive into host data
          pins_r.select_n <= 1'b1; // RULE13
          pins_r.write_strobe_n <= 1'b1; // RULE13
          write_r <= 1'b0; // RULE22
        end
        default: begin
          // deselect keeps address, gives standby on enable variant
          pins_r.select_n <= 1'b1; // RULE19 RULE20 RULE21
          pins_r.write_strobe_n <= 1'b1;
          write_r <= 1'b0; // RULE15
        end
      endcase
    end
  end

  assign addr_inputs_o = pins_r.addr;
  assign select_n_o = pins_r.select_n;
  assign write_strobe_n_o = pins_r.write_strobe_n;
  assign data_o = wdata_r;
  // host drives only during write; released before memory can redrive
  assign data_oe_o = write_r; // RULE22

  ////////////////////////////////////////////////////////////////////////////
  // read capture: sampled two cycles late to cover synchroniser

  logic [1:0] sample_pipe_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_pipe_r <= '0;
      sample_wait_r <= 1'b0;
    end else begin
      sample_wait_r <= (state_r == ST_READ) && cnt_done; // RULE4 RULE8
      sample_pipe_r <= {sample_pipe_r[0], sample_wait_r};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= sample_pipe_r[0];
      if (sample_pipe_r[0]) rdata_o <= data_sync; // RULE5
    end
  end

endmodule

// >>> testbench/sram_host_checker.sv
// pin timing checker for the static memory host controller
// assumes binding to sram_host; one clock, asynchronous low reset
`timescale 1ns/1ps
module sram_host_checker
  import sram_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic req_ready_o,
  input wire logic rdata_valid_o,
  input wire logic [ADDR_W-1:0] addr_inputs_o,
  input wire logic select_n_o,
  input wire logic write_strobe_n_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  read_strobe_a: assert property (!select_n_o && !data_oe_o |-> write_strobe_n_o)
    else $error("write strobe low during a read");
  write_sel_a: assert property (!write_strobe_n_o |-> !select_n_o && data_oe_o)
    else $error("write strobe low without select or driven data");
  addr_hold_a: assert property (!write_strobe_n_o |=> $stable(addr_inputs_o) && $stable(data_o))
    else $error("address or data moved while strobe low");
  data_setup_a: assert property ($fell(write_strobe_n_o) |-> data_oe_o && $stable(data_o))
    else $error("write data not set up before strobe");
  strobe_width_a: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*3] ##1 write_strobe_n_o)
    else $error("write strobe width wrong");
  read_access_a: assert property ($fell(select_n_o) && !data_oe_o |-> !select_n_o [*2])
    else $error("read select shorter than access time");
  deselect_gap_a: assert property ($rose(select_n_o) |=> select_n_o)
    else $error("no deselect gap between accesses");
  oe_in_select_a: assert property (data_oe_o |-> !select_n_o)
    else $error("data driven outside a selected cycle");
  supply_hold_a: assert property (!supply_ok_i [*6] |-> !req_ready_o && select_n_o)
    else $error("access allowed with supply low");
  read_seen_c: cover property (rdata_valid_o);
  write_seen_c: cover property ($fell(write_strobe_n_o));
  supply_seen_c: cover property ($fell(supply_ok_i));
endmodule

bind sram_host sram_host_checker chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .supply_ok_i(supply_ok_i), .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o),
  .addr_inputs_o(addr_inputs_o), .select_n_o(select_n_o), .write_strobe_n_o(write_strobe_n_o),
  .data_o(data_o), .data_oe_o(data_oe_o));

// >>> testbench/sram_mem_model.sv
// behavioural 4k x 4 static memory at its pins
// assumes zero-delay pins; undriven data shows the inverse of the last value
`timescale 1ns/1ps
module sram_mem_model
  import sram_host_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_inputs_i,
  input wire logic select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [DATA_W-1:0] din_i,
  output logic [DATA_W-1:0] dq_o,
  output logic drive_o
);
  logic [DATA_W-1:0] mem_r [MEM_WORDS];
  logic [DATA_W-1:0] last_r = 4'h0;
  assign drive_o = !select_n_i && write_strobe_n_i;
  // write ends on the first rising edge of select or strobe
  wire wr_mode = !select_n_i && !write_strobe_n_i;
  always @(negedge wr_mode) begin
    mem_r[addr_inputs_i] <= din_i;
  end
  always @(drive_o or addr_inputs_i) begin
    if (drive_o) begin
      last_r = mem_r[addr_inputs_i];
    end
  end
  assign dq_o = drive_o ? mem_r[addr_inputs_i] : ~last_r;
endmodule

// >>> testbench/sram_host_tb.sv
// self-checking bench for the static memory host controller
// assumes sram_mem_model on the pins and the bound checker
`timescale 1ns/1ps
module sram_host_tb;
  import sram_host_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  mem_req_t req_i = '0;
  logic supply_ok_i = 1'b1;
  logic req_ready_o, rdata_valid_o, busy_o, select_n_o, write_strobe_n_o, data_oe_o, mem_drive;
  logic [DATA_W-1:0] rdata_o, data_o, data_i, mem_dq;
  logic [ADDR_W-1:0] addr_inputs_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #10 mclk_i = ~mclk_i;
  assign data_i = data_oe_o ? data_o : mem_dq;
  sram_host uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
    .supply_ok_i(supply_ok_i), .busy_o(busy_o), .addr_inputs_o(addr_inputs_o),
    .select_n_o(select_n_o), .write_strobe_n_o(write_strobe_n_o), .data_i(data_i),
    .data_o(data_o), .data_oe_o(data_oe_o));
  sram_mem_model mem (.addr_inputs_i(addr_inputs_o), .select_n_i(select_n_o),
    .write_strobe_n_i(write_strobe_n_o), .din_i(data_o), .dq_o(mem_dq), .drive_o(mem_drive));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // host and memory never drive the data lines together
  always @(negedge mclk_i) begin
    if (rst_n_i && data_oe_o) check(16'(mem_drive), 16'h0);
  end
  task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    #1 req_valid_i = 1'b1;
    req_i = '{write: w, addr: a, wdata: d};
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      #1 n++;
    end
    check(16'(req_ready_o), 16'h1);
    @(posedge mclk_i);
    #1 req_valid_i = 1'b0;
    check(16'(busy_o), 16'h1);
  endtask
  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int n;
    n = 0;
    send(1'b0, a, 4'h0);
    while (rdata_valid_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1 n++;
    end
    check(16'(rdata_valid_o), 16'h1);
    check(16'(rdata_o), 16'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_write_read;
    logic [ADDR_W-1:0] a [4] = '{12'h000, 12'hFFF, 12'hA5A, 12'h5A5};
    for (int i = 0; i < 4; i++) send(1'b1, a[i], 4'(i * 5 + 3));
    for (int i = 0; i < 4; i++) read_chk(a[i], 4'(i * 5 + 3));
  endtask
  task automatic s_overwrite;
    send(1'b1, 12'h123, 4'hF);
    send(1'b1, 12'h123, 4'h0);
    read_chk(12'h123, 4'h0);
    read_chk(12'hFFF, 4'h8);
  endtask
  task automatic s_supply;
    @(posedge mclk_i);
    #1 supply_ok_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 check(16'({req_ready_o, select_n_o}), 16'h1);
    supply_ok_i = 1'b1;
    send(1'b1, 12'h7E7, 4'h6);
    read_chk(12'h7E7, 4'h6);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    check(16'({select_n_o, write_strobe_n_o, data_oe_o}), 16'h6);
    #1 rst_n_i = 1'b1;
    s_write_read();
    s_overwrite();
    s_supply();
    test_done();
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
